// ===== verilog/lbm_params.svh
// constants of the line overhead monitor: register indices, bit positions,
// reset values and frame counts
// assumes inclusion by bare name from the package and the monitor
`ifndef LBM_PARAMS_SVH
`define LBM_PARAMS_SVH

// register indices; byte address is four times the index
`define LBM_IDX_IRQ_EN    10'h0E0
`define LBM_IDX_STATUS    10'h0E1
`define LBM_IDX_CFG       10'h0E2
`define LBM_IDX_SF_PER0   10'h0E3
`define LBM_IDX_SF_PER1   10'h0E4
`define LBM_IDX_SF_PER2   10'h0E5
`define LBM_IDX_SF_SAT0   10'h0E6
`define LBM_IDX_SF_SAT1   10'h0E7
`define LBM_IDX_SF_DEC0   10'h0E8
`define LBM_IDX_SF_DEC1   10'h0E9
`define LBM_IDX_SF_CLR0   10'h0EA
`define LBM_IDX_SF_CLR1   10'h0EB
`define LBM_IDX_SD_PER0   10'h0EC
`define LBM_IDX_SD_PER1   10'h0ED
`define LBM_IDX_SD_PER2   10'h0EE
`define LBM_IDX_SD_SAT0   10'h0EF
`define LBM_IDX_SD_SAT1   10'h0F0
`define LBM_IDX_SD_DEC0   10'h0F1
`define LBM_IDX_SD_DEC1   10'h0F2
`define LBM_IDX_SD_CLR0   10'h0F3
`define LBM_IDX_SD_CLR1   10'h0F4
`define LBM_IDX_K1_HOLD   10'h0F5
`define LBM_IDX_K2_HOLD   10'h0F6
`define LBM_IDX_SYNC_HOLD 10'h0F7

// configuration bit positions
`define LBM_CFG_SYNC_CAP  7
`define LBM_CFG_SF_EN     6
`define LBM_CFG_SF_SMODE  5
`define LBM_CFG_SF_CMODE  4
`define LBM_CFG_SD_EN     3
`define LBM_CFG_SD_SMODE  2
`define LBM_CFG_SD_CMODE  1

// reset values
`define LBM_RST_BYTE      8'h00

// frame counts and limits
`define LBM_APS_RUN       2'h3
`define LBM_APS_FAIL      4'hC
`define LBM_SYNC_RUN      4'h8
`define LBM_LONG_LAST     6'h3F
`define LBM_SAT_OFF       12'hFFF
`define LBM_ACC_MAX       17'h0FFFF

// bus responses
`define LBM_RESP_OKAY     2'h0
`define LBM_RESP_SLVERR   2'h2

`endif

// ===== verilog/lbm_pkg.sv
// types of the line overhead monitor
// assumes lbm_params.svh is on the include path
`include "lbm_params.svh"
package lbm_pkg;

   typedef struct packed {
      logic        awvalid;
      logic [11:0] awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [11:0] araddr;
      logic        rready;
   } lbm_axi_req_type;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } lbm_axi_rsp_type;

   typedef struct packed {
      logic        frame;
      logic [11:0] b2_err;
      logic [7:0]  k1;
      logic [7:0]  k2;
      logic [3:0]  sync_nibble;
   } lbm_ovh_type;

   typedef struct packed {
      logic        en;
      logic        cmode;
      logic        smode;
      logic [23:0] period;
      logic [11:0] sth;
      logic [11:0] dth;
      logic [11:0] cth;
   } lbm_ber_cfg_type;

   typedef struct packed {
      logic [23:0]      frame_cnt;
      logic [15:0]      sub_acc;
      logic [7:0][15:0] subtot;
      logic [2:0]       slot;
      logic [5:0]       long_cnt;
      logic [21:0]      long_acc;
      logic             alarm;
   } lbm_ber_type;

   typedef enum logic [1:0] {
      LBM_WR_IDLE = 2'b01,
      LBM_WR_RESP = 2'b10
   } lbm_wr_state_type;

   typedef struct packed {
      lbm_wr_state_type wr_state;
      logic             aw_got;
      logic             w_got;
      logic [9:0]       aw_idx;
      logic [7:0]       wdata;
      logic             wstrb0;
      logic [1:0]       bresp;
      logic             rvalid;
      logic [7:0]       rdata;
      logic [1:0]       rresp;
   } lbm_axi_state_type;

   typedef struct packed {
      logic [4:0]        irq_en;
      logic [7:0]        cfg;
      logic [23:0]       sf_period;
      logic [11:0]       sf_sth;
      logic [11:0]       sf_dth;
      logic [11:0]       sf_cth;
      logic [23:0]       sd_period;
      logic [11:0]       sd_sth;
      logic [11:0]       sd_dth;
      logic [11:0]       sd_cth;
      logic [4:0]        events;
      lbm_ber_type       sd;
      lbm_ber_type       sf;
      logic [7:0]        k1_prev;
      logic [7:0]        k2_prev;
      logic [1:0]        k1_run;
      logic [1:0]        pair_run;
      logic [3:0]        fail_cnt;
      logic              fail_state;
      logic [7:0]        k1_hold;
      logic [7:0]        k2_hold;
      logic [3:0]        nib_prev;
      logic [3:0]        nib_run;
      logic [3:0]        sync_hold;
      lbm_axi_state_type axi;
      logic              irq;
   } lbm_state_type;

endpackage

// ===== verilog/lbm_monitor.sv
// line overhead monitor: b2 error rate alarms, protection byte failure,
// k1/k2 and sync status capture, clear-on-read events, axi4-lite registers
// assumes one overhead update per frame, on core_clk, from the framer
//
// What this block does
// - enabled byte-failure event drives interrupt on alarm declare or removal
// - byte-failure alarm set after twelve frames without three equal k1
// - byte-failure alarm cleared after three consecutive equal k1 bytes
// - degrade alarm raised at or above declare threshold, lowered below clear threshold
// - fail alarm raised at or above declare threshold, lowered below clear threshold
// - degrade change event on each alarm change, cleared by status read
// - fail change event on each alarm change, cleared by status read
// - sync event when new sync value stored, cleared by status read
// - aps event when new k1/k2 code stored, cleared by status read
// - byte-failure event on each alarm change, cleared by status read
// - degrade clear window equals declare window, or eight times it
// - fail clear window equals declare window, or eight times it
// - degrade saturation caps errors per frame or per subtotal
// - fail saturation caps errors per frame or per subtotal
// - degrade enable accumulates errors; off resets to declaration monitoring
// - fail enable accumulates errors; off resets to declaration monitoring
// - sync capture stores nibble after eight equal frames, else every frame
// - fail period counts frames per subtotal; window is eight subtotals
// - degrade period counts frames per subtotal; window is eight subtotals
// - saturation threshold of all ones disables saturation
// - fail declared at count at least declare, removed below clear
// - degrade declared at count at least declare, removed below clear
`timescale 1ns/1ps
`default_nettype none
`include "lbm_params.svh"

module lbm_monitor (
   // clock and reset
   input  wire logic                     core_clk,
   input  wire logic                     rst_n,
   // register bus
   input  wire lbm_pkg::lbm_axi_req_type axi_req,
   output lbm_pkg::lbm_axi_rsp_type      axi_rsp,
   // receive overhead
   input  wire lbm_pkg::lbm_ovh_type     ovh,
   // interrupt
   output logic                          irq
);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic mapped(input logic [9:0] idx);
      mapped = (idx >= `LBM_IDX_IRQ_EN) && (idx <= `LBM_IDX_SYNC_HOLD);
   endfunction

   function automatic lbm_pkg::lbm_ber_type ber_step(
      input lbm_pkg::lbm_ber_type     s,
      input lbm_pkg::lbm_ber_cfg_type c,
      input logic                     frame,
      input logic [11:0]              err);
      lbm_pkg::lbm_ber_type n;
      logic [11:0]          e;
      logic [16:0]          acc;
      logic [18:0]          win;
      logic [21:0]          lng;
      logic                 cap_on;
      logic                 last;
      integer               i;
      n = s;
      cap_on = (c.sth != `LBM_SAT_OFF);
      e = (cap_on && !c.smode && err > c.sth) ? c.sth : err;
      acc = {1'b0, s.sub_acc} + {5'h00, e};
      if (acc[16]) begin
         acc = `LBM_ACC_MAX;
      end
      if (cap_on && c.smode && acc > {5'h00, c.sth}) begin
         acc = {5'h00, c.sth};
      end
      last = ({1'b0, s.frame_cnt} + 25'h0000001) >= {1'b0, c.period};
      win = 19'h00000;
      for (i = 0; i < 8; i = i + 1) begin
         win = win + {3'h0, (3'(i) == s.slot) ? acc[15:0] : s.subtot[i]};
      end
      lng = s.long_acc + {6'h00, acc[15:0]};
      if (!c.en) begin
         n = '0;
      end else if (frame) begin
         if (!last) begin
            n.frame_cnt = s.frame_cnt + 24'h000001;
            n.sub_acc = acc[15:0];
         end else begin
            n.frame_cnt = 24'h000000;
            n.sub_acc = 16'h0000;
            n.subtot[s.slot] = acc[15:0];
            n.slot = s.slot + 3'h1;
            n.long_cnt = s.long_cnt + 6'h01;
            n.long_acc = (s.long_cnt == `LBM_LONG_LAST) ? 22'h000000 : lng;
            if (!s.alarm && win >= {7'h00, c.dth}) begin
               n.alarm = 1'b1;
            end else if (s.alarm && !c.cmode && win < {7'h00, c.cth}) begin
               n.alarm = 1'b0;
            end else if (s.alarm && c.cmode && s.long_cnt == `LBM_LONG_LAST
                         && lng < {10'h000, c.cth}) begin
               n.alarm = 1'b0;
            end
         end
      end
      return n;
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   lbm_pkg::lbm_state_type   s;
   lbm_pkg::lbm_state_type   next_s;
   lbm_pkg::lbm_ber_cfg_type sd_cfg;
   lbm_pkg::lbm_ber_cfg_type sf_cfg;
   logic [9:0]               ar_idx;
   logic                     ar_take;
   logic [7:0]               status_byte;
   logic [4:0]               new_ev;
   logic [1:0]               k1_run_n;
   logic [1:0]               pair_run_n;
   logic [3:0]               fail_cnt_n;
   logic [3:0]               nib_run_n;

   assign sd_cfg = '{en:     s.cfg[`LBM_CFG_SD_EN],
                     cmode:  s.cfg[`LBM_CFG_SD_CMODE],
                     smode:  s.cfg[`LBM_CFG_SD_SMODE],
                     period: s.sd_period,
                     sth:    s.sd_sth,
                     dth:    s.sd_dth,
                     cth:    s.sd_cth};
   assign sf_cfg = '{en:     s.cfg[`LBM_CFG_SF_EN],
                     cmode:  s.cfg[`LBM_CFG_SF_CMODE],
                     smode:  s.cfg[`LBM_CFG_SF_SMODE],
                     period: s.sf_period,
                     sth:    s.sf_sth,
                     dth:    s.sf_dth,
                     cth:    s.sf_cth};

   assign ar_idx = axi_req.araddr[11:2];
   assign ar_take = axi_req.arvalid && !s.axi.rvalid;
   assign status_byte = {s.events, s.sf.alarm, s.sd.alarm, s.fail_state};

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_s = s;
      new_ev = 5'h00;
      k1_run_n = s.k1_run;
      pair_run_n = s.pair_run;
      fail_cnt_n = s.fail_cnt;
      nib_run_n = s.nib_run;

      // error rate monitors
      next_s.sd = ber_step(s.sd, sd_cfg, ovh.frame, ovh.b2_err);
      next_s.sf = ber_step(s.sf, sf_cfg, ovh.frame, ovh.b2_err);
      new_ev[0] = next_s.sd.alarm != s.sd.alarm;
      new_ev[1] = next_s.sf.alarm != s.sf.alarm;

      // protection bytes and sync status
      if (ovh.frame) begin
         next_s.k1_prev = ovh.k1;
         next_s.k2_prev = ovh.k2;
         next_s.nib_prev = ovh.sync_nibble;
         if (ovh.k1 != s.k1_prev) begin
            k1_run_n = 2'h1;
         end else if (s.k1_run != `LBM_APS_RUN) begin
            k1_run_n = s.k1_run + 2'h1;
         end
         if (ovh.k1 != s.k1_prev || ovh.k2 != s.k2_prev) begin
            pair_run_n = 2'h1;
         end else if (s.pair_run != `LBM_APS_RUN) begin
            pair_run_n = s.pair_run + 2'h1;
         end
         next_s.k1_run = k1_run_n;
         next_s.pair_run = pair_run_n;
         if (k1_run_n == `LBM_APS_RUN) begin
            fail_cnt_n = 4'h0;
            next_s.fail_state = 1'b0;
         end else begin
            if (s.fail_cnt != `LBM_APS_FAIL) begin
               fail_cnt_n = s.fail_cnt + 4'h1;
            end
            if (fail_cnt_n == `LBM_APS_FAIL) begin
               next_s.fail_state = 1'b1;
            end
         end
         next_s.fail_cnt = fail_cnt_n;
         if (pair_run_n == `LBM_APS_RUN
             && {ovh.k1, ovh.k2} != {s.k1_hold, s.k2_hold}) begin
            next_s.k1_hold = ovh.k1;
            next_s.k2_hold = ovh.k2;
            new_ev[3] = 1'b1;
         end
         if (ovh.sync_nibble != s.nib_prev) begin
            nib_run_n = 4'h1;
         end else if (s.nib_run != `LBM_SYNC_RUN) begin
            nib_run_n = s.nib_run + 4'h1;
         end
         next_s.nib_run = nib_run_n;
         if ((!s.cfg[`LBM_CFG_SYNC_CAP] || nib_run_n == `LBM_SYNC_RUN)
             && ovh.sync_nibble != s.sync_hold) begin
            next_s.sync_hold = ovh.sync_nibble;
            new_ev[2] = 1'b1;
         end
      end
      new_ev[4] = next_s.fail_state != s.fail_state;

      // write channel
      if (s.axi.wr_state == lbm_pkg::LBM_WR_RESP) begin
         if (axi_req.bready) begin
            next_s.axi.wr_state = lbm_pkg::LBM_WR_IDLE;
         end
      end else if (s.axi.aw_got && s.axi.w_got) begin
         next_s.axi.aw_got = 1'b0;
         next_s.axi.w_got = 1'b0;
         next_s.axi.wr_state = lbm_pkg::LBM_WR_RESP;
         next_s.axi.bresp = mapped(s.axi.aw_idx) ? `LBM_RESP_OKAY : `LBM_RESP_SLVERR;
         if (s.axi.wstrb0) begin
            unique case (s.axi.aw_idx)
               `LBM_IDX_IRQ_EN:  next_s.irq_en = s.axi.wdata[7:3];
               `LBM_IDX_CFG:     next_s.cfg = s.axi.wdata;
               `LBM_IDX_SF_PER0: next_s.sf_period[7:0] = s.axi.wdata;
               `LBM_IDX_SF_PER1: next_s.sf_period[15:8] = s.axi.wdata;
               `LBM_IDX_SF_PER2: next_s.sf_period[23:16] = s.axi.wdata;
               `LBM_IDX_SF_SAT0: next_s.sf_sth[7:0] = s.axi.wdata;
               `LBM_IDX_SF_SAT1: next_s.sf_sth[11:8] = s.axi.wdata[3:0];
               `LBM_IDX_SF_DEC0: next_s.sf_dth[7:0] = s.axi.wdata;
               `LBM_IDX_SF_DEC1: next_s.sf_dth[11:8] = s.axi.wdata[3:0];
               `LBM_IDX_SF_CLR0: next_s.sf_cth[7:0] = s.axi.wdata;
               `LBM_IDX_SF_CLR1: next_s.sf_cth[11:8] = s.axi.wdata[3:0];
               `LBM_IDX_SD_PER0: next_s.sd_period[7:0] = s.axi.wdata;
               `LBM_IDX_SD_PER1: next_s.sd_period[15:8] = s.axi.wdata;
               `LBM_IDX_SD_PER2: next_s.sd_period[23:16] = s.axi.wdata;
               `LBM_IDX_SD_SAT0: next_s.sd_sth[7:0] = s.axi.wdata;
               `LBM_IDX_SD_SAT1: next_s.sd_sth[11:8] = s.axi.wdata[3:0];
               `LBM_IDX_SD_DEC0: next_s.sd_dth[7:0] = s.axi.wdata;
               `LBM_IDX_SD_DEC1: next_s.sd_dth[11:8] = s.axi.wdata[3:0];
               `LBM_IDX_SD_CLR0: next_s.sd_cth[7:0] = s.axi.wdata;
               `LBM_IDX_SD_CLR1: next_s.sd_cth[11:8] = s.axi.wdata[3:0];
               default:          next_s.irq_en = s.irq_en;
            endcase
         end
      end else begin
         if (axi_req.awvalid && !s.axi.aw_got) begin
            next_s.axi.aw_got = 1'b1;
            next_s.axi.aw_idx = axi_req.awaddr[11:2];
         end
         if (axi_req.wvalid && !s.axi.w_got) begin
            next_s.axi.w_got = 1'b1;
            next_s.axi.wdata = axi_req.wdata[7:0];
            next_s.axi.wstrb0 = axi_req.wstrb[0];
         end
      end

      // read channel
      if (s.axi.rvalid && axi_req.rready) begin
         next_s.axi.rvalid = 1'b0;
      end
      if (ar_take) begin
         next_s.axi.rvalid = 1'b1;
         next_s.axi.rresp = mapped(ar_idx) ? `LBM_RESP_OKAY : `LBM_RESP_SLVERR;
         unique case (ar_idx)
            `LBM_IDX_IRQ_EN:    next_s.axi.rdata = {s.irq_en, 3'h0};
            `LBM_IDX_STATUS:    next_s.axi.rdata = status_byte;
            `LBM_IDX_CFG:       next_s.axi.rdata = s.cfg;
            `LBM_IDX_SF_PER0:   next_s.axi.rdata = s.sf_period[7:0];
            `LBM_IDX_SF_PER1:   next_s.axi.rdata = s.sf_period[15:8];
            `LBM_IDX_SF_PER2:   next_s.axi.rdata = s.sf_period[23:16];
            `LBM_IDX_SF_SAT0:   next_s.axi.rdata = s.sf_sth[7:0];
            `LBM_IDX_SF_SAT1:   next_s.axi.rdata = {4'h0, s.sf_sth[11:8]};
            `LBM_IDX_SF_DEC0:   next_s.axi.rdata = s.sf_dth[7:0];
            `LBM_IDX_SF_DEC1:   next_s.axi.rdata = {4'h0, s.sf_dth[11:8]};
            `LBM_IDX_SF_CLR0:   next_s.axi.rdata = s.sf_cth[7:0];
            `LBM_IDX_SF_CLR1:   next_s.axi.rdata = {4'h0, s.sf_cth[11:8]};
            `LBM_IDX_SD_PER0:   next_s.axi.rdata = s.sd_period[7:0];
            `LBM_IDX_SD_PER1:   next_s.axi.rdata = s.sd_period[15:8];
            `LBM_IDX_SD_PER2:   next_s.axi.rdata = s.sd_period[23:16];
            `LBM_IDX_SD_SAT0:   next_s.axi.rdata = s.sd_sth[7:0];
            `LBM_IDX_SD_SAT1:   next_s.axi.rdata = {4'h0, s.sd_sth[11:8]};
            `LBM_IDX_SD_DEC0:   next_s.axi.rdata = s.sd_dth[7:0];
            `LBM_IDX_SD_DEC1:   next_s.axi.rdata = {4'h0, s.sd_dth[11:8]};
            `LBM_IDX_SD_CLR0:   next_s.axi.rdata = s.sd_cth[7:0];
            `LBM_IDX_SD_CLR1:   next_s.axi.rdata = {4'h0, s.sd_cth[11:8]};
            `LBM_IDX_K1_HOLD:   next_s.axi.rdata = s.k1_hold;
            `LBM_IDX_K2_HOLD:   next_s.axi.rdata = s.k2_hold;
            `LBM_IDX_SYNC_HOLD: next_s.axi.rdata = {4'h0, s.sync_hold};
            default:            next_s.axi.rdata = `LBM_RST_BYTE;
         endcase
      end

      // events: status read clears, a new event in the same cycle wins
      next_s.events = s.events;
      if (ar_take && ar_idx == `LBM_IDX_STATUS) begin
         next_s.events = 5'h00;
      end
      next_s.events = next_s.events | {new_ev[4], new_ev[3], new_ev[2], new_ev[1], new_ev[0]};
      next_s.irq = |(next_s.events & s.irq_en);
   end

   // ------------------------------------------------------------
   // registers and outputs
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s <= '0;
         s.axi.wr_state <= lbm_pkg::LBM_WR_IDLE;
      end else begin
         s <= next_s;
      end
   end

   assign axi_rsp.awready = (s.axi.wr_state == lbm_pkg::LBM_WR_IDLE) && !s.axi.aw_got;
   assign axi_rsp.wready = (s.axi.wr_state == lbm_pkg::LBM_WR_IDLE) && !s.axi.w_got;
   assign axi_rsp.bvalid = s.axi.wr_state == lbm_pkg::LBM_WR_RESP;
   assign axi_rsp.bresp = s.axi.bresp;
   assign axi_rsp.arready = !s.axi.rvalid;
   assign axi_rsp.rvalid = s.axi.rvalid;
   assign axi_rsp.rdata = {24'h000000, s.axi.rdata};
   assign axi_rsp.rresp = s.axi.rresp;
   assign irq = s.irq;

endmodule
`default_nettype wire

// ===== testbench/lbm_ovh_src.sv
// upstream overhead source: one frame pulse per send
// assumes the core_clk of the monitor
`timescale 1ns/1ps
`default_nettype none
module lbm_ovh_src (
   // clock
   input  wire logic                 core_clk,
   // overhead towards the monitor
   output var  lbm_pkg::lbm_ovh_type ovh
);
   initial ovh = '0;
   // frame data, then idle with inverted data since it is not held
   task automatic send(input logic [7:0] k1, input logic [7:0] k2,
                       input logic [3:0] nb, input logic [11:0] e);
      @(posedge core_clk);
      ovh <= {1'b1, e, k1, k2, nb};
      @(posedge core_clk);
      ovh <= {1'b0, ~e, ~k1, ~k2, ~nb};
      repeat (2) @(posedge core_clk);
   endtask
endmodule
`default_nettype wire

// ===== testbench/lbm_monitor_sva.sv
// port checker of the line overhead monitor
// assumes binding into lbm_monitor
`timescale 1ns/1ps
`default_nettype none
module lbm_monitor_sva (
   // clock and reset
   input wire logic                     core_clk,
   input wire logic                     rst_n,
   // watched ports
   input wire lbm_pkg::lbm_axi_req_type axi_req,
   input wire lbm_pkg::lbm_axi_rsp_type axi_rsp,
   input wire lbm_pkg::lbm_ovh_type     ovh,
   input wire logic                     irq
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   bresp_hold_a: assert property (axi_rsp.bvalid && !axi_req.bready
      |=> axi_rsp.bvalid && $stable(axi_rsp.bresp)) else $error("write response dropped");
   rdata_hold_a: assert property (axi_rsp.rvalid && !axi_req.rready
      |=> axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("read data dropped");
   read_answer_a: assert property (axi_req.arvalid && axi_rsp.arready
      |=> axi_rsp.rvalid && axi_rsp.rdata[31:8] == 24'h000000) else $error("read late");
   write_answer_a: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid
      && axi_rsp.wready |-> ##2 axi_rsp.bvalid) else $error("write late");
   ar_block_a: assert property (axi_rsp.rvalid |-> !axi_rsp.arready) else $error("ar open");
   aw_block_a: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
      else $error("aw open");
   irq_rise_a: assert property ($rose(irq) |-> $past(ovh.frame)
      || axi_rsp.bvalid || $past(axi_rsp.bvalid)) else $error("irq without event");
   irq_fall_a: assert property ($fell(irq) |-> $past(axi_req.arvalid)
      || axi_rsp.bvalid || $past(axi_rsp.bvalid)) else $error("irq lost");
endmodule
bind lbm_monitor lbm_monitor_sva sva (.core_clk(core_clk), .rst_n(rst_n),
   .axi_req(axi_req), .axi_rsp(axi_rsp), .ovh(ovh), .irq(irq));
`default_nettype wire

// ===== testbench/lbm_monitor_tb_top.sv
// register-level tests of the line overhead monitor
// assumes lbm_params.svh on the include path
`timescale 1ns/1ps
`default_nettype none
`include "lbm_params.svh"
module lbm_monitor_tb_top;
   localparam logic [9:0] ST = `LBM_IDX_STATUS;
   localparam logic [9:0] CF = `LBM_IDX_CFG;
   logic                     core_clk = 1'b0;
   logic                     rst_n = 1'b0;
   lbm_pkg::lbm_axi_req_type req = '0;
   lbm_pkg::lbm_axi_rsp_type rsp;
   lbm_pkg::lbm_ovh_type     ovh;
   logic                     irq;
   int                       errors = 0;
   int                       tests_run = 0;
   always #2.5 core_clk = ~core_clk;
   lbm_monitor dut (.core_clk(core_clk), .rst_n(rst_n), .axi_req(req), .axi_rsp(rsp),
      .ovh(ovh), .irq(irq));
   lbm_ovh_src src (.core_clk(core_clk), .ovh(ovh));
   // ----------------------------------
   // bus and compare tasks
   // ----------------------------------
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      logic a;
      logic w;
      a = 1'b0;
      w = 1'b0;
      @(posedge core_clk);
      req.awaddr <= {idx, 2'b00};
      req.wdata <= {24'h000000, d};
      req.wstrb <= 4'hF;
      req.awvalid <= 1'b1;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      while (!(a && w)) begin
         @(negedge core_clk);
         a = a | rsp.awready;
         w = w | rsp.wready;
         @(posedge core_clk);
         if (a) req.awvalid <= 1'b0;
         if (w) req.wvalid <= 1'b0;
      end
      do @(negedge core_clk); while (!rsp.bvalid);
      @(posedge core_clk);
      req.bready <= 1'b0;
   endtask
   task automatic rd(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] r);
      @(posedge core_clk);
      req.araddr <= {idx, 2'b00};
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      do @(negedge core_clk); while (!rsp.arready);
      @(posedge core_clk);
      req.arvalid <= 1'b0;
      do @(negedge core_clk); while (!rsp.rvalid);
      @(posedge core_clk);
      d = rsp.rdata;
      r = rsp.rresp;
      req.rready <= 1'b0;
   endtask
   task automatic rc(input logic [9:0] idx, input logic [7:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      rd(idx, d, r);
      check($sformatf("reg %h", idx), d, {24'h000000, e});
      check("rresp", {30'h0, r}, {30'h0, `LBM_RESP_OKAY});
   endtask
   task automatic fr(input int n, input logic [7:0] k1, input logic [3:0] nb,
                     input logic [11:0] e);
      repeat (n) src.send(k1, 8'h3C, nb, e);
   endtask
   task automatic ber(input logic [9:0] b, input logic [7:0] s0, input logic [7:0] s1);
      wr(b, 8'h01);
      wr(b + 10'h3, s0);
      wr(b + 10'h4, s1);
      wr(b + 10'h5, 8'h03);
      wr(b + 10'h7, 8'h01);
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge core_clk);
      errors++;
      give_verdict();
   end
   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      for (int i = `LBM_IDX_IRQ_EN; i <= `LBM_IDX_SYNC_HOLD; i++) rc(i[9:0], 8'h00);
      rd(10'h010, d, r);
      check("unmapped data", d, 32'h00000000);
      check("unmapped resp", {30'h0, r}, {30'h0, `LBM_RESP_SLVERR});
      wr(`LBM_IDX_IRQ_EN, 8'h80);
      for (int i = 0; i < 11; i++) fr(1, i[7:0], 4'h0, 12'h000);
      rc(ST, 8'h00);
      fr(1, 8'h0B, 4'h0, 12'h000);
      check("irq", {31'h0, irq}, 32'h00000001);
      rc(ST, 8'h81);
      rc(ST, 8'h01);
      check("irq", {31'h0, irq}, 32'h00000000);
      fr(3, 8'h5A, 4'h0, 12'h000);
      check("irq", {31'h0, irq}, 32'h00000001);
      rc(ST, 8'hC0);
      rc(`LBM_IDX_K1_HOLD, 8'h5A);
      rc(`LBM_IDX_K2_HOLD, 8'h3C);
      fr(1, 8'h5A, 4'h9, 12'h000);
      rc(ST, 8'h20);
      rc(`LBM_IDX_SYNC_HOLD, 8'h09);
      wr(CF, 8'h80);
      fr(7, 8'h5A, 4'h4, 12'h000);
      rc(`LBM_IDX_SYNC_HOLD, 8'h09);
      fr(1, 8'h5A, 4'h4, 12'h000);
      rc(`LBM_IDX_SYNC_HOLD, 8'h04);
      rc(ST, 8'h20);
      ber(`LBM_IDX_SF_PER0, 8'hFF, 8'h0F);
      wr(CF, 8'hC0);
      fr(1, 8'h5A, 4'h4, 12'h002);
      rc(ST, 8'h00);
      fr(1, 8'h5A, 4'h4, 12'h001);
      check("irq", {31'h0, irq}, 32'h00000000);
      rc(ST, 8'h14);
      fr(7, 8'h5A, 4'h4, 12'h000);
      rc(ST, 8'h04);
      fr(1, 8'h5A, 4'h4, 12'h000);
      rc(ST, 8'h10);
      ber(`LBM_IDX_SD_PER0, 8'h02, 8'h00);
      wr(CF, 8'h88);
      fr(1, 8'h5A, 4'h4, 12'h005);
      rc(ST, 8'h00);
      fr(1, 8'h5A, 4'h4, 12'h005);
      rc(ST, 8'h0A);
      wr(CF, 8'h80);
      rc(ST, 8'h08);
      wr(`LBM_IDX_SD_PER0, 8'h02);
      wr(CF, 8'h8E);
      fr(2, 8'h5A, 4'h4, 12'h002);
      rc(ST, 8'h00);
      fr(2, 8'h5A, 4'h4, 12'h002);
      rc(ST, 8'h0A);
      fr(250, 8'h5A, 4'h4, 12'h000);
      rc(ST, 8'h02);
      fr(2, 8'h5A, 4'h4, 12'h000);
      rc(ST, 8'h08);
      give_verdict();
   end
endmodule
`default_nettype wire
